// ---- hdl/cgi_consts.vh ----
`ifndef CGI_CONSTS_VH
`define CGI_CONSTS_VH

// register indices; byte address is four times the index
`define CGI_IDX_LIVE      8'h0D
`define CGI_IDX_MASK      8'h0E
`define CGI_IDX_POL       8'h0F
`define CGI_IDX_FLAG      8'h10
`define CGI_IDX_CTL       8'h11
`define CGI_IDX_SYS_STAT  8'h20
`define CGI_IDX_SYS_CLR   8'h21
`define CGI_IDX_SYS_EN    8'h22
`define CGI_ADDR(i)       ((i) << 2)

// source bit positions
`define CGI_BIT_A_LOL     7
`define CGI_BIT_A_LOS     6
`define CGI_BIT_A_CAL     5
`define CGI_BIT_B_LOL     4
`define CGI_BIT_B_LOS     3
`define CGI_BIT_B_CAL     2
`define CGI_BIT_A_SW      1
`define CGI_BIT_B_SW      0

// control register fields
`define CGI_CTL_AND_OR    1
`define CGI_CTL_EN        0

// system status events
`define CGI_EVT_IRQ_RISE  0
`define CGI_EVT_FLAG_SET  1

// reset values
`define CGI_RST_MASK      8'h00
`define CGI_RST_POL       8'h00
`define CGI_RST_FLAG      8'h00
`define CGI_RST_CTL       2'h0
`define CGI_RST_SYS       2'h0

// bus answers
`define CGI_RESP_OKAY     2'h0
`define CGI_RESP_SLVERR   2'h2

`endif

// ---- hdl/cgi_edge_flags.v ----
// per-source edge detect and sticky flag
module cgi_edge_flags #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // control
  input  wire [WIDTH-1:0] live,
  input  wire [WIDTH-1:0] edge_sel,
  input  wire             enable,
  input  wire [WIDTH-1:0] clear,
  // results
  output wire [WIDTH-1:0] flags,
  output wire [WIDTH-1:0] set_evt
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_src
      reg  prev_reg;
      reg  flag_reg;
      wire rise;
      wire fall;
      wire hit;
      assign rise = live[g] & ~prev_reg;
      assign fall = ~live[g] & prev_reg;
      // edges seen while disabled are dropped, not replayed on enable
      assign hit  = enable & (edge_sel[g] ? rise : fall);
      always @(posedge aclk) begin
        if (!aresetn) begin
          prev_reg <= 1'b0;
          flag_reg <= 1'b0;
        end else begin
          prev_reg <= live[g];
          if (hit) begin
            flag_reg <= 1'b1;
          end else if (clear[g]) begin
            flag_reg <= 1'b0;
          end
        end
      end
      assign flags[g]   = flag_reg;
      assign set_evt[g] = hit;
    end
  endgenerate

endmodule // cgi_edge_flags

// ---- hdl/cgi_src_sync.v ----
// per-bit three-stage synchroniser; a change is accepted once stages two and three agree
module cgi_src_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // raw pins and filtered levels
  input  wire [WIDTH-1:0] raw_in,
  output wire [WIDTH-1:0] level_out
);

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg s1_reg;
      reg s2_reg;
      reg s3_reg;
      reg lvl_reg;
      always @(posedge aclk) begin
        if (!aresetn) begin
          s1_reg  <= 1'b0;
          s2_reg  <= 1'b0;
          s3_reg  <= 1'b0;
          lvl_reg <= 1'b0;
        end else begin
          s1_reg <= raw_in[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          // stage one is read only by stage two
          if (s2_reg == s3_reg) begin
            lvl_reg <= s3_reg;
          end
        end
      end
      assign level_out[g] = lvl_reg;
    end
  endgenerate

endmodule // cgi_src_sync

// ---- hdl/cgi_top.v ----
// The AXI4-Lite interface to the registers was decided locally.
`include "cgi_consts.vh"

// interrupt logic of a dual pll clock generator, behind an axi4-lite slave
module cgi_top #(
  parameter ADDR_W = 8,
  parameter NSRC   = 8
) (
  // clock and reset
  input  wire              aclk,
  input  wire              aresetn,
  // axi4-lite write address
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  // axi4-lite write response
  output wire [1:0]        s_axi_bresp,
  output wire              s_axi_bvalid,
  input  wire              s_axi_bready,
  // axi4-lite read address
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  // axi4-lite read data
  output wire [31:0]       s_axi_rdata,
  output wire [1:0]        s_axi_rresp,
  output wire              s_axi_rvalid,
  input  wire              s_axi_rready,
  // pll status pins
  input  wire              pll_a_lock_lost,
  input  wire              pll_a_input_lost,
  input  wire              pll_a_vco_calibrating,
  input  wire              pll_b_lock_lost,
  input  wire              pll_b_input_lost,
  input  wire              pll_b_vco_calibrating,
  input  wire              pll_a_ref_switch_back,
  input  wire              pll_b_ref_switch_back,
  // interrupts
  output wire              irq_signal,
  output wire              irq
);

  // register state
  reg  [NSRC-1:0]   mask_reg;
  reg  [NSRC-1:0]   pol_reg;
  reg  [1:0]        ctl_reg;
  reg  [1:0]        sys_stat_reg;
  reg  [1:0]        sys_en_reg;
  reg               irq_sig_reg;
  reg               irq_reg;
  // write channel state
  reg               aw_full_reg;
  reg  [ADDR_W-1:0] aw_addr_reg;
  reg               w_full_reg;
  reg  [31:0]       w_data_reg;
  reg  [3:0]        w_strb_reg;
  reg               bvalid_reg;
  reg  [1:0]        bresp_reg;
  // read channel state
  reg               rvalid_reg;
  reg  [31:0]       rdata_reg;
  reg  [1:0]        rresp_reg;
  reg  [31:0]       rdata_next;
  reg  [1:0]        rresp_next;
  reg  [1:0]        bresp_next;

  wire [NSRC-1:0]   raw_src;
  wire [NSRC-1:0]   sync_src;
  wire [NSRC-1:0]   live;
  wire [NSRC-1:0]   flags;
  wire [NSRC-1:0]   set_evt;
  wire [NSRC-1:0]   flag_clr;
  wire [NSRC-1:0]   unmasked;
  wire              do_write;
  wire              wr_lane0;
  wire              combined;
  wire              irq_en;
  wire              and_mode;
  wire [1:0]        sys_evt;
  wire [1:0]        sys_clr;
  wire              do_read;
  wire              wsel_mask;
  wire              wsel_pol;
  wire              wsel_flag;
  wire              wsel_ctl;
  wire              wsel_sclr;
  wire              wsel_sen;
  wire              all_masked;
  wire              and_hit;
  wire              or_hit;

  // byte addresses held at the bus width, so decodes compare equal widths
  localparam [ADDR_W-1:0] ADR_LIVE = `CGI_ADDR(`CGI_IDX_LIVE);
  localparam [ADDR_W-1:0] ADR_MASK = `CGI_ADDR(`CGI_IDX_MASK);
  localparam [ADDR_W-1:0] ADR_POL  = `CGI_ADDR(`CGI_IDX_POL);
  localparam [ADDR_W-1:0] ADR_FLAG = `CGI_ADDR(`CGI_IDX_FLAG);
  localparam [ADDR_W-1:0] ADR_CTL  = `CGI_ADDR(`CGI_IDX_CTL);
  localparam [ADDR_W-1:0] ADR_STAT = `CGI_ADDR(`CGI_IDX_SYS_STAT);
  localparam [ADDR_W-1:0] ADR_SCLR = `CGI_ADDR(`CGI_IDX_SYS_CLR);
  localparam [ADDR_W-1:0] ADR_SEN  = `CGI_ADDR(`CGI_IDX_SYS_EN);

  // source order shared by every per-source register
  assign raw_src[`CGI_BIT_A_LOL] = pll_a_lock_lost;
  assign raw_src[`CGI_BIT_A_LOS] = pll_a_input_lost;
  assign raw_src[`CGI_BIT_A_CAL] = pll_a_vco_calibrating;
  assign raw_src[`CGI_BIT_B_LOL] = pll_b_lock_lost;
  assign raw_src[`CGI_BIT_B_LOS] = pll_b_input_lost;
  assign raw_src[`CGI_BIT_B_CAL] = pll_b_vco_calibrating;
  assign raw_src[`CGI_BIT_A_SW]  = pll_a_ref_switch_back;
  assign raw_src[`CGI_BIT_B_SW]  = pll_b_ref_switch_back;

  cgi_src_sync #(
    .WIDTH     (NSRC)
  ) u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .raw_in    (raw_src),
    .level_out (sync_src)
  );

  // live status never depends on the enable bit
  // an input loss also drops lock, so the lock loss bit is suppressed then
  assign live[`CGI_BIT_A_LOL] = sync_src[`CGI_BIT_A_LOL] & ~sync_src[`CGI_BIT_A_LOS];
  assign live[`CGI_BIT_B_LOL] = sync_src[`CGI_BIT_B_LOL] & ~sync_src[`CGI_BIT_B_LOS];
  assign live[`CGI_BIT_A_LOS] = sync_src[`CGI_BIT_A_LOS];
  assign live[`CGI_BIT_A_CAL] = sync_src[`CGI_BIT_A_CAL];
  assign live[`CGI_BIT_B_LOS] = sync_src[`CGI_BIT_B_LOS];
  assign live[`CGI_BIT_B_CAL] = sync_src[`CGI_BIT_B_CAL];
  assign live[`CGI_BIT_A_SW]  = sync_src[`CGI_BIT_A_SW];
  assign live[`CGI_BIT_B_SW]  = sync_src[`CGI_BIT_B_SW];

  assign irq_en   = ctl_reg[`CGI_CTL_EN];
  assign and_mode = ctl_reg[`CGI_CTL_AND_OR];

  // write path: address and data taken in either order, applied together
  assign s_axi_awready = ~aw_full_reg;
  assign s_axi_wready  = ~w_full_reg;
  assign do_write      = aw_full_reg & w_full_reg & ~bvalid_reg;
  assign wr_lane0      = do_write & w_strb_reg[0];
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // one select per written register keeps the decode in one place
  assign wsel_mask = (aw_addr_reg == ADR_MASK);
  assign wsel_pol  = (aw_addr_reg == ADR_POL);
  assign wsel_flag = (aw_addr_reg == ADR_FLAG);
  assign wsel_ctl  = (aw_addr_reg == ADR_CTL);
  assign wsel_sclr = (aw_addr_reg == ADR_SCLR);
  assign wsel_sen  = (aw_addr_reg == ADR_SEN);

  // a written zero clears, a written one leaves the flag alone
  assign flag_clr = (wr_lane0 && wsel_flag) ?
                    ~w_data_reg[NSRC-1:0] : {NSRC{1'b0}};

  cgi_edge_flags #(
    .WIDTH    (NSRC)
  ) u_flags (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .live     (live),
    .edge_sel (pol_reg),
    .enable   (irq_en),
    .clear    (flag_clr),
    .flags    (flags),
    .set_evt  (set_evt)
  );

  // combination; and mode with every source masked stays low
  assign unmasked   = flags & ~mask_reg;
  assign all_masked = &mask_reg;
  // an and over no sources would fire by itself, hence the extra term
  assign and_hit    = &(flags | mask_reg) & ~all_masked;
  assign or_hit     = |unmasked;
  assign combined   = irq_en & (and_mode ? and_hit : or_hit);

  always @* begin
    case (aw_addr_reg)
      ADR_LIVE,
      ADR_MASK,
      ADR_POL,
      ADR_FLAG,
      ADR_CTL,
      ADR_STAT,
      ADR_SCLR,
      ADR_SEN: bresp_next = `CGI_RESP_OKAY;
      default: bresp_next = `CGI_RESP_SLVERR;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= {ADDR_W{1'b0}};
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `CGI_RESP_OKAY;
      mask_reg    <= `CGI_RST_MASK;
      pol_reg     <= `CGI_RST_POL;
      ctl_reg     <= `CGI_RST_CTL;
      sys_en_reg  <= `CGI_RST_SYS;
    end else begin
      if (s_axi_awvalid && !aw_full_reg) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_full_reg) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= bresp_next;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
      // writes to read-only or unmapped words are answered and dropped
      if (wr_lane0 && wsel_mask) begin
        mask_reg <= w_data_reg[NSRC-1:0];
      end
      if (wr_lane0 && wsel_pol) begin
        pol_reg <= w_data_reg[NSRC-1:0];
      end
      if (wr_lane0 && wsel_ctl) begin
        ctl_reg <= w_data_reg[1:0];
      end
      if (wr_lane0 && wsel_sen) begin
        sys_en_reg <= w_data_reg[1:0];
      end
    end
  end

  // system event register: set beats a same-cycle write-one clear
  assign sys_evt[`CGI_EVT_IRQ_RISE] = combined & ~irq_sig_reg;
  assign sys_evt[`CGI_EVT_FLAG_SET] = |set_evt;
  assign sys_clr = (wr_lane0 && wsel_sclr) ?
                   w_data_reg[1:0] : 2'h0;

  always @(posedge aclk) begin
    if (!aresetn) begin
      sys_stat_reg <= `CGI_RST_SYS;
      irq_sig_reg  <= 1'b0;
      irq_reg      <= 1'b0;
    end else begin
      sys_stat_reg <= sys_evt | (sys_stat_reg & ~sys_clr);
      irq_sig_reg  <= combined;
      irq_reg      <= |(sys_stat_reg & sys_en_reg);
    end
  end

  assign irq_signal = irq_sig_reg;
  assign irq        = irq_reg;

  // read path: one cycle from address to data
  assign do_read       = s_axi_arvalid & ~rvalid_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always @* begin
    rdata_next = 32'h00000000;
    rresp_next = `CGI_RESP_OKAY;
    case (s_axi_araddr)
      ADR_LIVE: rdata_next[NSRC-1:0] = live;
      ADR_MASK: rdata_next[NSRC-1:0] = mask_reg;
      ADR_POL:  rdata_next[NSRC-1:0] = pol_reg;
      ADR_FLAG: rdata_next[NSRC-1:0] = flags;
      ADR_CTL:  rdata_next[1:0]      = ctl_reg;
      ADR_STAT: rdata_next[1:0]      = sys_stat_reg;
      ADR_SCLR: rdata_next           = 32'h00000000;
      ADR_SEN:  rdata_next[1:0]      = sys_en_reg;
      default:  rresp_next           = `CGI_RESP_SLVERR;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `CGI_RESP_OKAY;
    end else begin
      if (do_read) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rdata_next;
        rresp_reg  <= rresp_next;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

endmodule // cgi_top

// ---- verification/cgi_top_properties.sv ----
`include "cgi_consts.vh"

// port watch of cgi_top; mask and enable are shadowed from bus writes
module cgi_props (
  // clock and reset
  input logic        aclk,
  input logic        aresetn,
  // register bus
  input logic [7:0]  s_axi_awaddr,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // interrupts
  input logic        irq_signal,
  input logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_MSK = `CGI_ADDR(`CGI_IDX_MASK);
  localparam logic [7:0] A_CTL = `CGI_ADDR(`CGI_IDX_CTL);
  logic       en_sh;
  logic [7:0] msk_sh;
  logic       wr_go;
  // shadows assume address and data are taken together, full strobes
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always @(posedge aclk) begin
    if (!aresetn) begin
      en_sh  <= 1'h0;
      msk_sh <= 8'h00;
    end else if (wr_go && s_axi_awaddr == A_CTL) begin
      en_sh <= s_axi_wdata[`CGI_CTL_EN];
    end else if (wr_go && s_axi_awaddr == A_MSK) begin
      msk_sh <= s_axi_wdata[7:0];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped early");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_refused: assert property (wr_go |=> !s_axi_awready && !s_axi_wready)
    else $error("write taken while one is held");
  a_write_answer: assert property (wr_go |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_reset_quiet: assert property (disable iff (1'h0)
    !aresetn |=> !irq_signal && !irq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  a_off_no_irq: assert property ((!en_sh) [*4] |-> !irq_signal)
    else $error("interrupt while disabled");
  a_all_masked: assert property ((msk_sh == 8'hFF) [*4] |-> !irq_signal)
    else $error("interrupt with every source masked");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp))
    else $error("write answer code changed while held");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data changed while held");
endmodule // cgi_props

bind cgi_top cgi_props i_props (.*);

// ---- verification/cgi_top_tb.sv ----
`include "cgi_consts.vh"

module cgi_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] AL = `CGI_ADDR(`CGI_IDX_LIVE), AM = `CGI_ADDR(`CGI_IDX_MASK);
  localparam logic [7:0] AP = `CGI_ADDR(`CGI_IDX_POL), AF = `CGI_ADDR(`CGI_IDX_FLAG);
  localparam logic [7:0] AC = `CGI_ADDR(`CGI_IDX_CTL), AS = `CGI_ADDR(`CGI_IDX_SYS_STAT);
  localparam logic [7:0] AX = `CGI_ADDR(`CGI_IDX_SYS_CLR), AE = `CGI_ADDR(`CGI_IDX_SYS_EN);
  localparam logic [7:0] AU = 8'h60;
  logic        aclk = 1'h0, aresetn = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_rready = 1'h0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        irq_signal, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_v;
  logic [7:0]  src = 8'h00, fl = 8'h00, msk = 8'h00, pol = 8'h00, old;
  logic [1:0]  ctl = 2'h0;
  int          error_cnt = 0, n_checks = 0, seed = 32'hD751;

  cgi_top i_dut (
    .*,
    .pll_a_lock_lost       (src[`CGI_BIT_A_LOL]),
    .pll_a_input_lost      (src[`CGI_BIT_A_LOS]),
    .pll_a_vco_calibrating (src[`CGI_BIT_A_CAL]),
    .pll_b_lock_lost       (src[`CGI_BIT_B_LOL]),
    .pll_b_input_lost      (src[`CGI_BIT_B_LOS]),
    .pll_b_vco_calibrating (src[`CGI_BIT_B_CAL]),
    .pll_a_ref_switch_back (src[`CGI_BIT_A_SW]),
    .pll_b_ref_switch_back (src[`CGI_BIT_B_SW])
  );

  always #10 aclk = ~aclk;

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while ((s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready) && n < 50);
    // late bready exercises the held answer
    repeat (3) @(posedge aclk);
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_bvalid && n < 60);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, a == AU ? `CGI_RESP_SLVERR : `CGI_RESP_OKAY);
    if (!s_axi_bvalid) begin
      error_cnt++;
      wrap_up();
    end
  endtask

  task automatic rd(input logic [7:0] a);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'h0;
    @(posedge aclk);
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
    end while (!s_axi_rvalid && n < 60);
    s_axi_rready <= 1'h0;
    rd_v = s_axi_rdata;
    chk(s_axi_rresp, a == AU ? `CGI_RESP_SLVERR : `CGI_RESP_OKAY);
    if (!s_axi_rvalid) begin
      error_cnt++;
      wrap_up();
    end
  endtask

  // lock loss is hidden while the same pll has lost its input
  function automatic logic [7:0] eff(input logic [7:0] s);
    return s & ~{s[6], 2'h0, s[3], 4'h0};
  endfunction

  function automatic logic eirq();
    return ctl[0] && (ctl[1] ? (msk != 8'hFF && &(fl | msk)) : |(fl & ~msk));
  endfunction

  task automatic cfg(input logic [7:0] m, p, input logic [1:0] c);
    wr(AM, {24'h0, m});
    wr(AP, {24'h0, p});
    wr(AC, {30'h0, c});
    msk = m;
    pol = p;
    ctl = c;
    rd(AM);
    chk(rd_v, {24'h0, m});
    rd(AC);
    chk(rd_v, {30'h0, c});
  endtask

  task automatic clr(input logic [7:0] w);
    wr(AF, {24'h0, w});
    fl = fl & w;
    rd(AF);
    chk(rd_v, {24'h0, fl});
  endtask

  task automatic step(input logic [7:0] s);
    old = eff(src);
    src <= s;
    repeat (10) @(posedge aclk);
    if (ctl[0]) fl = fl | (pol & ~old & eff(s)) | (~pol & old & ~eff(s));
    rd(AL);
    chk(rd_v, {24'h0, eff(s)});
    rd(AF);
    chk(rd_v, {24'h0, fl});
    chk({31'h0, irq_signal}, {31'h0, eirq()});
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    rd(AM);
    chk(rd_v, 32'h0);
    rd(AP);
    chk(rd_v, 32'h0);
    rd(AF);
    chk(rd_v, 32'h0);
    rd(AC);
    chk(rd_v, 32'h0);
    rd(AU);
    wr(AU, 32'h1);
    wr(AM, 32'hFFFFFF5A);
    rd(AM);
    chk(rd_v, 32'h5A);
    // walk each source through both edge senses
    for (int p = 1; p >= 0; p--) begin
      cfg(8'h00, p ? 8'hFF : 8'h00, 2'h1);
      for (int i = 0; i < 8; i++) begin
        step(8'h01 << i);
        step(8'h00);
      end
      clr(8'h0F);
      clr(8'h00);
    end
    step(8'hC0);
    step(8'h00);
    cfg(8'hFF, 8'hFF, 2'h1);
    step(8'h11);
    cfg(8'hFF, 8'hFF, 2'h3);
    step(8'h11);
    cfg(8'hFC, 8'hFF, 2'h3);
    clr(8'h00);
    step(8'h02);
    step(8'h03);
    cfg(8'h00, 8'hFF, 2'h0);
    step(8'h00);
    step(8'hFF);
    // system line follows a fresh flag set
    cfg(8'h00, 8'hFF, 2'h1);
    clr(8'h00);
    // start from a clean event register so the line proves a fresh set
    wr(AX, 32'h3);
    wr(AE, 32'h2);
    chk({31'h0, irq}, 32'h0);
    step(8'h00);
    step(8'h20);
    chk({31'h0, irq}, 32'h1);
    rd(AS);
    chk(rd_v, 32'h3);
    wr(AX, 32'h3);
    rd(AS);
    chk(rd_v, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(AE, 32'h0);
    repeat (24) begin
      cfg(8'($random(seed)), 8'($random(seed)), 2'($random(seed)));
      if ($random(seed) % 4 == 0) clr(8'($random(seed)));
      step(8'($random(seed)));
    end
    // reset in mid-run: registers and flags return to their reset values
    aresetn <= 1'h0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    fl = 8'h00;
    rd(AF);
    chk(rd_v, 32'h0);
    rd(AC);
    chk(rd_v, 32'h0);
    rd(AM);
    chk(rd_v, 32'h0);
    chk({31'h0, irq_signal}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    cfg(8'h00, 8'h00, 2'h1);
    step(8'h00);
    wrap_up();
  end
endmodule // cgi_top_tb
